// *** pkg/bfq_pkg.sv ***
// Purpose : shared constants and types of the bidirectional queue port control
// Assumes : one system clock; port clocks arrive as sampled levels
// Notes   : every use is written bfq_pkg::name

package bfq_pkg;

	localparam int         DATA_W      = 18;
	localparam int         PTR_W       = 10;
	localparam int         DEPTH       = 512;
	localparam int         OFS_W       = 8;
	localparam int         STATUS_W    = 4;

	localparam logic [7:0] OFS_DEFAULT = 8'h80;
	localparam logic [9:0] HALF_LEVEL  = 10'h100;
	localparam logic [9:0] FULL_LEVEL  = 10'h200;
	localparam logic [1:0] IR_DELAY    = 2'h2;

	localparam logic [7:0] OFS_STATUS  = 8'h00;
	localparam logic [7:0] OFS_MASK    = 8'h04;
	localparam logic [7:0] OFS_FILL    = 8'h08;
	localparam int         FILL_BA_LSB = 16;

	localparam int         ST_AB_HALF  = 0;
	localparam int         ST_BA_HALF  = 1;
	localparam int         ST_AB_REFUSE = 2;
	localparam int         ST_BA_REFUSE = 3;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

	typedef enum logic [2:0] {
		PRG_IDLE  = 3'h1,
		PRG_FIRST = 3'h2,
		PRG_DONE  = 3'h4
	} bfq_prog_t;

	typedef struct packed {
		logic              port_clock;
		logic              direction_select;
		logic              select_n;
		logic              write_enable;
		logic              read_enable;
		logic              offset_program_n;
		logic [DATA_W-1:0] data;
	} bfq_port_in_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic              data_oe;
		logic              input_ready;
		logic              output_ready;
		logic              threshold_flag;
		logic              half_full;
	} bfq_port_out_t;

	typedef struct packed {
		logic [PTR_W-1:0]  wptr;
		logic [PTR_W-1:0]  rptr;
		logic [PTR_W-1:0]  wsync1;
		logic [PTR_W-1:0]  wsync2;
		logic [PTR_W-1:0]  rsync1;
		logic [PTR_W-1:0]  rsync2;
		logic [1:0]        ir_cnt;
		logic              ir;
		logic              orr;
		logic [DATA_W-1:0] dout;
		logic [OFS_W-1:0]  x;
		logic [OFS_W-1:0]  y;
		logic              prog_ok;
		bfq_prog_t         prog;
		logic              half;
		logic              thr;
	} bfq_queue_t;

	localparam bfq_queue_t QUEUE_RST = '{
		wptr: 10'h000, rptr: 10'h000, wsync1: 10'h000, wsync2: 10'h000,
		rsync1: 10'h000, rsync2: 10'h000, ir_cnt: 2'h0, ir: 1'h0,
		orr: 1'h0, dout: 18'h00000, x: OFS_DEFAULT, y: OFS_DEFAULT,
		prog_ok: 1'h1, prog: PRG_IDLE, half: 1'h0, thr: 1'h1
	};

	typedef struct packed {
		logic [1:0]          clk_prev;
		logic [1:0]          oe;
		logic [STATUS_W-1:0] status;
		logic [STATUS_W-1:0] mask;
		logic                irq;
		logic [31:0]         hrdata;
		logic                wr_pend;
		logic [7:0]          wr_addr;
	} bfq_top_t;

	localparam bfq_top_t TOP_RST = '{
		clk_prev: 2'h0, oe: 2'h0, status: 4'h0, mask: 4'h0,
		irq: 1'h0, hrdata: 32'h00000000, wr_pend: 1'h0, wr_addr: 8'h00
	};

endpackage : bfq_pkg

// *** rtl/bfq_port_ctrl.sv ***
// Purpose : port control of a two-queue bidirectional FIFO, 512 x 18 each way
// Assumes : port clocks and pins are sampled on MCLK_I, running well faster
// Notes   : a word written on port A is read on port B and the reverse
// Function
// - A write stores A data into a-to-b queue when direction high, enabled, selected, ready.
// - A read takes next b-to-a word when direction low, enabled, selected, output ready.
// - Port B mirrors port A on its own clock and queues.
// - A port's data drivers are released while its direction select is high.
// - Threshold flag high when fill at most X or at least 512 minus Y.
// - Offsets programmable only after queue reset, before the first stored word.
// - First rising edge with program enable low loads both offsets from data low byte.
// - Second such edge reloads only the almost-full offset.
// - Each offset is unsigned eight bits, at most 255.
// - Without programming both offsets are 128.
// - Programming edges store no data word.
// - The b-to-a threshold is programmed alike from port B.
// - Half-full high at 256 or more words, low after queue reset.
// - Input ready low when full or in reset, high at second writer edge after.
// - Output ready low when empty, rises third reader edge after first word arrives.

`timescale 1ns/100ps
`default_nettype none

module bfq_port_ctrl (
	input  wire logic                 MCLK_I,
	input  wire logic                 RESET_I,
	input  wire logic                 AB_QUEUE_RESET_N_I,
	input  wire logic                 BA_QUEUE_RESET_N_I,
	input  wire bfq_pkg::bfq_port_in_t PORT_A_I,
	input  wire bfq_pkg::bfq_port_in_t PORT_B_I,
	output var  bfq_pkg::bfq_port_out_t PORT_A_O,
	output var  bfq_pkg::bfq_port_out_t PORT_B_O,
	input  wire logic                 HSEL_I,
	input  wire logic [31:0]          HADDR_I,
	input  wire logic [1:0]           HTRANS_I,
	input  wire logic                 HWRITE_I,
	input  wire logic [2:0]           HSIZE_I,
	input  wire logic [31:0]          HWDATA_I,
	input  wire logic                 HREADY_I,
	output logic [31:0]               HRDATA_O,
	output logic                      HREADYOUT_O,
	output logic                      HRESP_O,
	output logic                      IRQ_O
);

	////////////////////////////////////////////////////////////////////////////////
	// shared wiring

	bfq_pkg::bfq_port_in_t pin      [0:1];
	bfq_pkg::bfq_queue_t   que_r    [0:1];
	logic [9:0]            fill     [0:1];
	logic [1:0]            rise;
	logic [1:0]            ev_half;
	logic [1:0]            ev_refuse;
	logic [1:0]            qreset_n;
	bfq_pkg::bfq_top_t     top_r;
	bfq_pkg::bfq_top_t     top_nxt;

	assign pin[0]      = PORT_A_I;
	assign pin[1]      = PORT_B_I;
	assign qreset_n[0] = AB_QUEUE_RESET_N_I;
	assign qreset_n[1] = BA_QUEUE_RESET_N_I;

	// port clocks are levels here; an edge is a low sample followed by a high one
	assign rise[0] = PORT_A_I.port_clock & ~top_r.clk_prev[0];
	assign rise[1] = PORT_B_I.port_clock & ~top_r.clk_prev[1];

	////////////////////////////////////////////////////////////////////////////////
	// one queue per direction: q=0 written by A, read by B; q=1 the mirror

	genvar q;
	generate
		for (q = 0; q < 2; q++) begin : g_queue
			localparam int WP = q;
			localparam int RP = 1 - q;

			logic [bfq_pkg::DATA_W-1:0] mem [0:bfq_pkg::DEPTH-1];
			bfq_pkg::bfq_queue_t        q_nxt;
			logic                       prog_hold;
			logic                       wr_try;
			logic                       wr_do;
			logic                       rd_do;
			logic [9:0]                 fill_nxt;
			logic [9:0]                 afull_lvl;

			// rising edges with program enable low belong to programming until the first word is stored
			assign prog_hold = rise[WP] & ~pin[WP].offset_program_n
				& que_r[q].prog_ok;

			assign wr_try = rise[WP] & pin[WP].direction_select
				& pin[WP].write_enable & ~pin[WP].select_n
				& ~prog_hold;

			assign wr_do = wr_try & que_r[q].ir;

			assign rd_do = rise[RP] & ~pin[RP].direction_select
				& pin[RP].read_enable & ~pin[RP].select_n
				& que_r[q].orr;

			assign fill[q]      = que_r[q].wptr - que_r[q].rsync2;
			assign ev_refuse[q] = wr_try & ~que_r[q].ir;
			assign ev_half[q]   = q_nxt.half & ~que_r[q].half;

			always_comb begin
				q_nxt = que_r[q];

				// writer side: program, store, resample read pointer
				if (prog_hold) begin
					case (que_r[q].prog)
						bfq_pkg::PRG_IDLE: begin
							q_nxt.x    = pin[WP].data[bfq_pkg::OFS_W-1:0];
							q_nxt.y    = pin[WP].data[bfq_pkg::OFS_W-1:0];
							q_nxt.prog = bfq_pkg::PRG_FIRST;
						end
						bfq_pkg::PRG_FIRST: begin
							q_nxt.y    = pin[WP].data[bfq_pkg::OFS_W-1:0];
							q_nxt.prog = bfq_pkg::PRG_DONE;
						end
						bfq_pkg::PRG_DONE: begin
							q_nxt.prog = bfq_pkg::PRG_DONE;
						end
						default: begin
							q_nxt.prog = bfq_pkg::PRG_IDLE;
						end
					endcase
				end else if (rise[WP]) begin
					q_nxt.prog = bfq_pkg::PRG_IDLE;
				end

				if (wr_do) begin
					q_nxt.wptr    = que_r[q].wptr + 10'h001;
					q_nxt.prog_ok = 1'h0;
				end

				if (rise[WP]) begin
					q_nxt.rsync1 = que_r[q].rptr;
					q_nxt.rsync2 = que_r[q].rsync1;
					if (que_r[q].ir_cnt != bfq_pkg::IR_DELAY) begin
						q_nxt.ir_cnt = que_r[q].ir_cnt + 2'h1;
					end
				end

				// reader side: three reader edges from a store to the word showing
				if (rise[RP]) begin
					q_nxt.wsync1 = que_r[q].wptr;
					q_nxt.wsync2 = que_r[q].wsync1;
					if (!que_r[q].orr || rd_do) begin
						if (que_r[q].rptr != que_r[q].wsync2) begin
							q_nxt.dout = mem[que_r[q].rptr[8:0]];
							q_nxt.rptr = que_r[q].rptr + 10'h001;
							q_nxt.orr  = 1'h1;
						end else begin
							// last word stays on the outputs once empty
							q_nxt.orr  = 1'h0;
						end
					end
				end

				// flags follow the writer's view of the fill level
				fill_nxt  = q_nxt.wptr - q_nxt.rsync2;
				afull_lvl = bfq_pkg::FULL_LEVEL - {2'h0, q_nxt.y};
				q_nxt.ir  = (q_nxt.ir_cnt == bfq_pkg::IR_DELAY)
					&& (fill_nxt != bfq_pkg::FULL_LEVEL);
				q_nxt.half = (fill_nxt >= bfq_pkg::HALF_LEVEL);
				q_nxt.thr  = (fill_nxt <= {2'h0, q_nxt.x})
					|| (fill_nxt >= afull_lvl);

				// queue reset overrides everything, offsets back to 128
				if (RESET_I || !qreset_n[q]) begin
					q_nxt = bfq_pkg::QUEUE_RST;
				end
			end

			always_ff @(posedge MCLK_I) begin
				que_r[q] <= q_nxt;
			end

			// the array holds no reset; pointers decide what is valid
			always_ff @(posedge MCLK_I) begin
				if (wr_do) begin
					mem[que_r[q].wptr[8:0]] <= pin[WP].data;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// bus slave, events and port output enables

	logic       accept;
	logic       rd_status;
	logic [7:0] addr_lo;

	assign addr_lo   = HADDR_I[7:0];
	assign accept    = HSEL_I & HREADY_I & (HTRANS_I == bfq_pkg::HTRANS_NONSEQ);
	assign rd_status = accept & ~HWRITE_I & (addr_lo == bfq_pkg::OFS_STATUS);

	always_comb begin
		top_nxt          = top_r;
		top_nxt.clk_prev = {PORT_B_I.port_clock, PORT_A_I.port_clock};

		// drivers on only for a selected port in the read direction
		top_nxt.oe[0] = ~PORT_A_I.direction_select & ~PORT_A_I.select_n;
		top_nxt.oe[1] = ~PORT_B_I.direction_select & ~PORT_B_I.select_n;

		// write data phase; the address was taken the cycle before
		top_nxt.wr_pend = 1'h0;
		if (top_r.wr_pend && (top_r.wr_addr == bfq_pkg::OFS_MASK)) begin
			top_nxt.mask = HWDATA_I[bfq_pkg::STATUS_W-1:0];
		end

		if (accept) begin
			top_nxt.hrdata = 32'h00000000;
			if (HWRITE_I) begin
				top_nxt.wr_pend = 1'h1;
				top_nxt.wr_addr = addr_lo;
			end else begin
				case (addr_lo)
					bfq_pkg::OFS_STATUS: begin
						top_nxt.hrdata[bfq_pkg::STATUS_W-1:0] = top_r.status;
					end
					bfq_pkg::OFS_MASK: begin
						top_nxt.hrdata[bfq_pkg::STATUS_W-1:0] = top_r.mask;
					end
					bfq_pkg::OFS_FILL: begin
						top_nxt.hrdata[9:0] = fill[0];
						top_nxt.hrdata[bfq_pkg::FILL_BA_LSB +: 10] = fill[1];
					end
					default: begin
						top_nxt.hrdata = 32'h00000000;
					end
				endcase
			end
		end

		// a read clears the sticky bits, but an event in that cycle survives
		if (rd_status) begin
			top_nxt.status = 4'h0;
		end
		top_nxt.status[bfq_pkg::ST_AB_HALF]   = top_nxt.status[bfq_pkg::ST_AB_HALF]
			| ev_half[0];
		top_nxt.status[bfq_pkg::ST_BA_HALF]   = top_nxt.status[bfq_pkg::ST_BA_HALF]
			| ev_half[1];
		top_nxt.status[bfq_pkg::ST_AB_REFUSE] = top_nxt.status[bfq_pkg::ST_AB_REFUSE]
			| ev_refuse[0];
		top_nxt.status[bfq_pkg::ST_BA_REFUSE] = top_nxt.status[bfq_pkg::ST_BA_REFUSE]
			| ev_refuse[1];

		top_nxt.irq = |(top_nxt.status & top_nxt.mask);

		if (RESET_I) begin
			top_nxt = bfq_pkg::TOP_RST;
		end
	end

	always_ff @(posedge MCLK_I) begin
		top_r <= top_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, taken from registers except HREADYOUT_O and HRESP_O, which are tied to constants

	// zero wait states; HSIZE_I is not checked, every access acts on a word
	assign HREADYOUT_O = 1'h1;
	assign HRESP_O     = bfq_pkg::HRESP_OKAY;
	assign HRDATA_O    = top_r.hrdata;
	assign IRQ_O       = top_r.irq;

	assign PORT_A_O.data           = que_r[1].dout;
	assign PORT_A_O.data_oe        = top_r.oe[0];
	assign PORT_A_O.input_ready    = que_r[0].ir;
	assign PORT_A_O.output_ready   = que_r[1].orr;
	assign PORT_A_O.threshold_flag = que_r[0].thr;
	assign PORT_A_O.half_full      = que_r[0].half;

	assign PORT_B_O.data           = que_r[0].dout;
	assign PORT_B_O.data_oe        = top_r.oe[1];
	assign PORT_B_O.input_ready    = que_r[1].ir;
	assign PORT_B_O.output_ready   = que_r[0].orr;
	assign PORT_B_O.threshold_flag = que_r[1].thr;
	assign PORT_B_O.half_full      = que_r[1].half;

endmodule : bfq_port_ctrl

`default_nettype wire

// *** sim/bfq_port_agent.sv ***
// Purpose: far-side port logic driving one queue port
// Assumes: called right after a rising MCLK edge
// Notes: port clock stands still between operations
`timescale 1ns/100ps
`default_nettype none

module bfq_port_agent (
	input  wire logic                  MCLK_I,
	output var  bfq_pkg::bfq_port_in_t PORT_O
);
	initial PORT_O = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 18'h00000};
	////////////////////////////////
	// c is {direction, select_n, write, read, program_n}; controls move only while clock low
	task automatic cyc(input logic [4:0] c, input logic [17:0] d);
		PORT_O <= '{1'h0, c[4], c[3], c[2], c[1], c[0], d};
		repeat (2) @(posedge MCLK_I);
		PORT_O.port_clock <= 1'h1;
		repeat (2) @(posedge MCLK_I);
		PORT_O.port_clock <= 1'h0;
		// released data shows the inverse so a stale sample cannot pass
		PORT_O.data <= ~d;
		repeat (2) @(posedge MCLK_I);
	endtask : cyc
endmodule : bfq_port_agent
`default_nettype wire

// *** sim/bfq_port_monitor.sv ***
// Purpose: port-level checks of the queue port control
// Assumes: bound to bfq_port_ctrl, one clock domain
// Notes: deselect or write direction releases data one MCLK late
`timescale 1ns/100ps
`default_nettype none

module bfq_port_monitor (
	input wire logic                   MCLK_I,
	input wire logic                   RESET_I,
	input wire logic                   AB_QUEUE_RESET_N_I,
	input wire logic                   BA_QUEUE_RESET_N_I,
	input wire bfq_pkg::bfq_port_in_t  PORT_A_I,
	input wire bfq_pkg::bfq_port_in_t  PORT_B_I,
	input wire bfq_pkg::bfq_port_out_t PORT_A_O,
	input wire bfq_pkg::bfq_port_out_t PORT_B_O,
	input wire logic                   IRQ_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RESET_I);
	////////////////////////////////
	oe_a_release_a: assert property (
		PORT_A_I.direction_select || PORT_A_I.select_n |=> !PORT_A_O.data_oe)
		else $error("port A drives while released");
	oe_b_release_a: assert property (
		PORT_B_I.direction_select || PORT_B_I.select_n |=> !PORT_B_O.data_oe)
		else $error("port B drives while released");
	ab_reset_flags_a: assert property (
		!AB_QUEUE_RESET_N_I |=> !PORT_A_O.input_ready && !PORT_A_O.half_full
		&& PORT_A_O.threshold_flag && !PORT_B_O.output_ready)
		else $error("a-to-b reset flags wrong");
	ba_reset_flags_a: assert property (
		!BA_QUEUE_RESET_N_I |=> !PORT_B_O.input_ready && !PORT_B_O.half_full
		&& PORT_B_O.threshold_flag && !PORT_A_O.output_ready)
		else $error("b-to-a reset flags wrong");
	ab_ir_rise_a: assert property (
		$rose(PORT_A_O.input_ready) |-> $past(PORT_A_I.port_clock)
		|| $past(PORT_A_I.port_clock, 2) || $past(PORT_A_I.port_clock, 3))
		else $error("input ready rose away from a writer edge");
	ab_or_rise_a: assert property (
		$rose(PORT_B_O.output_ready) |-> $past(PORT_B_I.port_clock)
		|| $past(PORT_B_I.port_clock, 2) || $past(PORT_B_I.port_clock, 3))
		else $error("output ready rose away from a reader edge");
	ab_data_hold_a: assert property (
		$fell(PORT_B_O.output_ready) && $past(AB_QUEUE_RESET_N_I) && !$past(RESET_I)
		|-> $stable(PORT_B_O.data))
		else $error("port B word lost when emptied");
	ba_data_hold_a: assert property (
		$fell(PORT_A_O.output_ready) && $past(BA_QUEUE_RESET_N_I) && !$past(RESET_I)
		|-> $stable(PORT_A_O.data))
		else $error("port A word lost when emptied");
	cover property ($rose(PORT_B_O.output_ready));
	cover property (PORT_A_O.half_full && !PORT_A_O.input_ready);
	cover property ($rose(IRQ_O));
endmodule : bfq_port_monitor

bind bfq_port_ctrl bfq_port_monitor bfq_port_monitor_inst (
	.MCLK_I(MCLK_I), .RESET_I(RESET_I), .AB_QUEUE_RESET_N_I(AB_QUEUE_RESET_N_I),
	.BA_QUEUE_RESET_N_I(BA_QUEUE_RESET_N_I), .PORT_A_I(PORT_A_I), .PORT_B_I(PORT_B_I),
	.PORT_A_O(PORT_A_O), .PORT_B_O(PORT_B_O), .IRQ_O(IRQ_O));
`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: directed test of the queue port control
// Assumes: each port operation spans 6 MCLK
// Notes: flags use the writer view, so checks follow writer edges
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	localparam logic [4:0]  WR = 5'h15, RD = 5'h03, PRG = 5'h14, IDL = 5'h19, LSN = 5'h01;
	logic                   mclk = 1'h0;
	logic                   rst = 1'h1;
	logic                   ab_rst_n = 1'h0;
	logic                   ba_rst_n = 1'h0;
	logic                   hsel = 1'h0;
	logic                   hwrite = 1'h0;
	logic [1:0]             htrans = 2'h0;
	logic [31:0]            haddr = 32'h0;
	logic [31:0]            hwdata = 32'h0;
	logic [31:0]            rd_bus, v;
	logic                   hready, hresp, irq;
	bfq_pkg::bfq_port_in_t  pa_i, pb_i;
	bfq_pkg::bfq_port_out_t pa_o, pb_o;
	int                     mismatches = 0;
	int                     comparisons = 0;

	always #12.5 mclk = ~mclk;

	bfq_port_agent port_a_agent (.MCLK_I(mclk), .PORT_O(pa_i));
	bfq_port_agent port_b_agent (.MCLK_I(mclk), .PORT_O(pb_i));
	bfq_port_ctrl bfq_port_ctrl_inst (
		.MCLK_I(mclk), .RESET_I(rst), .AB_QUEUE_RESET_N_I(ab_rst_n),
		.BA_QUEUE_RESET_N_I(ba_rst_n), .PORT_A_I(pa_i), .PORT_B_I(pb_i),
		.PORT_A_O(pa_o), .PORT_B_O(pb_o), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
		.HREADY_I(hready), .HRDATA_O(rd_bus), .HREADYOUT_O(hready), .HRESP_O(hresp),
		.IRQ_O(irq));
	////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge mclk);
		hsel <= 1'h1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= bfq_pkg::HTRANS_NONSEQ;
		do @(posedge mclk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hready !== 1'h1);
		v = rd_bus;
		hsel <= 1'h0;
	endtask : bus

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	////////////////////////////////
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'h0;
		@(posedge mclk);
		chk(pa_o.threshold_flag, 1'h1);
		fork
			repeat (4) port_a_agent.cyc(IDL, 18'h00000);
			repeat (4) port_b_agent.cyc(IDL, 18'h00000);
		join
		ab_rst_n <= 1'h1;
		ba_rst_n <= 1'h1;
		fork
			port_a_agent.cyc(IDL, 18'h00000);
			port_b_agent.cyc(IDL, 18'h00000);
		join
		chk(pa_o.input_ready, 1'h0);
		fork
			port_a_agent.cyc(IDL, 18'h00000);
			port_b_agent.cyc(IDL, 18'h00000);
		join
		chk(pa_o.input_ready, 1'h1);
		chk(pb_o.input_ready, 1'h1);
		port_a_agent.cyc(PRG, 18'h00002);
		port_a_agent.cyc(PRG, 18'h3FFFF);
		port_a_agent.cyc(5'h1D, 18'h00000);
		port_a_agent.cyc(5'h11, 18'h00000);
		bus(1'h0, bfq_pkg::OFS_FILL, 32'h0);
		chk(v, 32'h0);
		for (int i = 1; i <= 512; i++) begin
			port_a_agent.cyc(WR, 18'h20000 + 18'(i));
			chk(pa_o.threshold_flag, i <= 2 || i >= 257);
			chk(pa_o.half_full, i >= 256);
			chk(pa_o.input_ready, i < 512);
		end
		chk(pa_o.data_oe, 1'h0);
		port_a_agent.cyc(WR, 18'h3FFFF);
		bus(1'h0, bfq_pkg::OFS_FILL, 32'h0);
		chk(v, 32'h00000200);
		chk(irq, 1'h0);
		bus(1'h1, bfq_pkg::OFS_MASK, 32'h00000005);
		repeat (2) @(posedge mclk);
		chk(irq, 1'h1);
		bus(1'h0, bfq_pkg::OFS_STATUS, 32'h0);
		chk(v, 32'h00000005);
		repeat (2) @(posedge mclk);
		chk(irq, 1'h0);
		bus(1'h0, bfq_pkg::OFS_MASK, 32'h0);
		chk(v, 32'h00000005);
		bus(1'h0, 8'h40, 32'h0);
		chk(v, 32'h0);
		chk(hresp, bfq_pkg::HRESP_OKAY);
		repeat (2) port_b_agent.cyc(LSN, 18'h00000);
		chk(pb_o.output_ready, 1'h0);
		port_b_agent.cyc(LSN, 18'h00000);
		chk(pb_o.output_ready, 1'h1);
		chk(pb_o.data, 18'h20001);
		chk(pb_o.data_oe, 1'h1);
		for (int i = 2; i <= 512; i++) begin
			port_b_agent.cyc(RD, 18'h00000);
			chk(pb_o.data, 18'h20000 + 18'(i));
		end
		port_b_agent.cyc(RD, 18'h00000);
		chk(pb_o.output_ready, 1'h0);
		chk(pb_o.data, 18'h20200);
		repeat (2) port_a_agent.cyc(IDL, 18'h00000);
		chk(pa_o.input_ready, 1'h1);
		chk(pa_o.half_full, 1'h0);
		for (int i = 1; i <= 130; i++) begin
			port_b_agent.cyc(WR, 18'h10000 + 18'(i));
			chk(pb_o.threshold_flag, i <= 128);
		end
		repeat (3) port_a_agent.cyc(LSN, 18'h00000);
		chk(pa_o.output_ready, 1'h1);
		chk(pa_o.data, 18'h10001);
		port_a_agent.cyc(RD, 18'h00000);
		chk(pa_o.data, 18'h10002);
		port_a_agent.cyc(5'h0B, 18'h00000);
		chk(pa_o.data, 18'h10002);
		chk(pb_o.half_full, 1'h0);
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
